// ===== hw/rsr_pkg.sv
// Constants shared by the rotate, subtract and return execution block.
// Assumes an APB master on the register side and a single core clock.
// How it works
// - Rotate-left shifts the operand left, old carry enters bit 0, one cycle.
// - Rotate-left: old carry to bit 0, bit 7 to carry, bits 6..0 up one.
// - Rotate-right: old carry to bit 7, bits 7..1 down, bit 0 to carry.
// - For rotates and register subtract, destination bit 0 writes the accumulator, 1 writes the addressed register back.
// - Return loads pc from stack top, drops level by one unless the stack is empty, two cycles, flags kept.
// - Register subtract computes register plus inverted accumulator plus carry, routed by destination.
// - Immediate subtract computes immediate plus inverted accumulator plus carry into the accumulator.
// - Special-page store copies the accumulator into entry 0..21, flags kept.
`default_nettype none
package rsr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int RSR_ADDR_W = 12;
  localparam logic [11:0] RSR_OFF_INSTR = 12'h000;
  localparam logic [11:0] RSR_OFF_STATUS = 12'h004;
  localparam logic [11:0] RSR_OFF_ACCUM = 12'h008;
  localparam logic [11:0] RSR_OFF_PC = 12'h00C;
  localparam logic [11:0] RSR_OFF_PUSH = 12'h010;
  localparam logic [11:0] RSR_OFF_MEM_ADDR = 12'h014;
  localparam logic [11:0] RSR_OFF_MEM_DATA = 12'h018;
  localparam logic [11:0] RSR_OFF_SPEC_ADDR = 12'h01C;
  localparam logic [11:0] RSR_OFF_SPEC_DATA = 12'h020;

  localparam logic [3:0] RSR_SEL_NONE = 4'h0;
  localparam logic [3:0] RSR_SEL_INSTR = 4'h1;
  localparam logic [3:0] RSR_SEL_STATUS = 4'h2;
  localparam logic [3:0] RSR_SEL_ACCUM = 4'h3;
  localparam logic [3:0] RSR_SEL_PC = 4'h4;
  localparam logic [3:0] RSR_SEL_PUSH = 4'h5;
  localparam logic [3:0] RSR_SEL_MEM_ADDR = 4'h6;
  localparam logic [3:0] RSR_SEL_MEM_DATA = 4'h7;
  localparam logic [3:0] RSR_SEL_SPEC_ADDR = 4'h8;
  localparam logic [3:0] RSR_SEL_SPEC_DATA = 4'h9;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int RSR_INSTR_OP_LSB = 0;
  localparam int RSR_INSTR_DEST_BIT = 3;
  localparam int RSR_INSTR_ADDR_LSB = 8;
  localparam int RSR_INSTR_IMM_LSB = 16;
  localparam int RSR_ST_CARRY_BIT = 0;
  localparam int RSR_ST_ZERO_BIT = 1;
  localparam int RSR_ST_HALF_BIT = 2;
  localparam int RSR_ST_BUSY_BIT = 3;
  localparam int RSR_ST_LEVEL_LSB = 8;

  // ----------------------------------------------------------------------
  // Operations and limits
  // ----------------------------------------------------------------------
  localparam logic [2:0] rotate_left_carry_op = 3'h0;
  localparam logic [2:0] rotate_right_carry_op = 3'h1;
  localparam logic [2:0] subroutine_return_op = 3'h2;
  localparam logic [2:0] reg_sub_borrow_op = 3'h3;
  localparam logic [2:0] imm_sub_borrow_op = 3'h4;
  localparam logic [2:0] special_page_store_op = 3'h5;

  localparam logic RSR_DEST_ACCUM = 1'h0;
  localparam logic RSR_DEST_REG = 1'h1;
  localparam int RSR_MEM_DEPTH = 128;
  localparam int RSR_SPEC_COUNT = 22;
  localparam logic [6:0] RSR_SPEC_LAST = 7'h15;

  typedef enum logic [1:0] {RSR_IDLE, RSR_EXEC, RSR_RETURN_WAIT} rsr_state_t;

endpackage
`default_nettype wire

// ===== hw/rsr_alu.sv
// Combinational rotate and subtract-with-borrow datapath.
// Assumes the caller registers the result and selects which flags to keep.
`timescale 1ns/100ps
`default_nettype none
module rsr_alu (
  input wire logic [2:0] op,
  input wire logic [7:0] operand,
  input wire logic [7:0] accum,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic half_out,
  output logic zero_out
);

  logic [4:0] low_sum;
  logic [8:0] full_sum;

  always_comb begin
    low_sum = {1'h0, operand[3:0]} + {1'h0, ~accum[3:0]} + {4'h0, carry_in};
    full_sum = {1'h0, operand} + {1'h0, ~accum} + {8'h00, carry_in};
    result = full_sum[7:0];
    carry_out = full_sum[8];
    half_out = low_sum[4];
    if (op == rsr_pkg::rotate_left_carry_op) begin
      result = {operand[6:0], carry_in};
      carry_out = operand[7];
    end else if (op == rsr_pkg::rotate_right_carry_op) begin
      result = {carry_in, operand[7:1]};
      carry_out = operand[0];
    end
    zero_out = (result == 8'h00);
  end

endmodule
`default_nettype wire

// ===== hw/rsr_stack.sv
// Hardware return stack holding program counter values.
// Assumes push and pop never arrive in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module rsr_stack #(
  parameter int DEPTH = 8,
  parameter int PCW = 10,
  parameter int LVW = $clog2(DEPTH + 1)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [PCW-1:0] push_data,
  input wire logic pop,
  output logic [PCW-1:0] top,
  output logic [LVW-1:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][PCW-1:0] ent;
    logic [LVW-1:0] level;
  } rsr_stack_t;

  rsr_stack_t q;
  rsr_stack_t d;

  // A push into a full stack is dropped rather than overwriting the oldest entry.
  always_comb begin
    d = q;
    if (push && (q.level != LVW'(DEPTH))) begin
      d.ent[q.level] = push_data;
      d.level = q.level + 1'h1;
    end else if (pop && (q.level != '0)) begin
      d.level = q.level - 1'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign top = (q.level == '0) ? '0 : q.ent[q.level - 1'h1];
  assign level = q.level;

endmodule
`default_nettype wire

// ===== hw/rsr_exec.sv
// Execution unit for rotate, subtract-with-borrow, return and special-page store.
// Assumes an APB master; the instruction is issued by writing the instruction word.
`timescale 1ns/100ps
`default_nettype none
module rsr_exec #(
  parameter int PCW = 10,
  parameter int STACK_DEPTH = 8,
  parameter int MEM_DEPTH = rsr_pkg::RSR_MEM_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsr_pkg::RSR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int LVW = $clog2(STACK_DEPTH + 1);

  typedef struct packed {
    rsr_pkg::rsr_state_t st;
    logic [31:0] prdata;
    logic [2:0] op;
    logic dest;
    logic [6:0] raddr;
    logic [7:0] imm;
    logic [7:0] accumulator_reg;
    logic carry;
    logic zero;
    logic half_carry_flag;
    logic [PCW-1:0] pc;
    logic [6:0] mem_addr;
    logic [4:0] spec_addr;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [rsr_pkg::RSR_SPEC_COUNT-1:0][7:0] special_function_register;
  } rsr_core_t;

  rsr_core_t q;
  rsr_core_t d;

  logic [3:0] sel;
  logic busy;
  logic wr_fire;
  logic push;
  logic pop;
  logic [31:0] rdata;
  logic [7:0] alu_operand;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_half;
  logic alu_zero;
  logic [PCW-1:0] stack_top;
  logic [LVW-1:0] stack_level;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic [3:0] rsr_decode(input logic [rsr_pkg::RSR_ADDR_W-1:0] a);
    logic [3:0] s;
    s = rsr_pkg::RSR_SEL_NONE;
    if (a == rsr_pkg::RSR_OFF_INSTR) begin
      s = rsr_pkg::RSR_SEL_INSTR;
    end else if (a == rsr_pkg::RSR_OFF_STATUS) begin
      s = rsr_pkg::RSR_SEL_STATUS;
    end else if (a == rsr_pkg::RSR_OFF_ACCUM) begin
      s = rsr_pkg::RSR_SEL_ACCUM;
    end else if (a == rsr_pkg::RSR_OFF_PC) begin
      s = rsr_pkg::RSR_SEL_PC;
    end else if (a == rsr_pkg::RSR_OFF_PUSH) begin
      s = rsr_pkg::RSR_SEL_PUSH;
    end else if (a == rsr_pkg::RSR_OFF_MEM_ADDR) begin
      s = rsr_pkg::RSR_SEL_MEM_ADDR;
    end else if (a == rsr_pkg::RSR_OFF_MEM_DATA) begin
      s = rsr_pkg::RSR_SEL_MEM_DATA;
    end else if (a == rsr_pkg::RSR_OFF_SPEC_ADDR) begin
      s = rsr_pkg::RSR_SEL_SPEC_ADDR;
    end else if (a == rsr_pkg::RSR_OFF_SPEC_DATA) begin
      s = rsr_pkg::RSR_SEL_SPEC_DATA;
    end
    return s;
  endfunction

  assign sel = rsr_decode(paddr);
  assign busy = (q.st != rsr_pkg::RSR_IDLE);
  // Writes stall while an instruction runs so software never races the datapath.
  assign pready = !(psel && penable && pwrite && busy);
  assign pslverr = psel && penable && (sel == rsr_pkg::RSR_SEL_NONE);
  assign wr_fire = psel && penable && pwrite && !busy;
  assign prdata = q.prdata;

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  always_comb begin
    rdata = '0;
    if (sel == rsr_pkg::RSR_SEL_INSTR) begin
      rdata[rsr_pkg::RSR_INSTR_OP_LSB +: 3] = q.op;
      rdata[rsr_pkg::RSR_INSTR_DEST_BIT] = q.dest;
      rdata[rsr_pkg::RSR_INSTR_ADDR_LSB +: 7] = q.raddr;
      rdata[rsr_pkg::RSR_INSTR_IMM_LSB +: 8] = q.imm;
    end else if (sel == rsr_pkg::RSR_SEL_STATUS) begin
      rdata[rsr_pkg::RSR_ST_CARRY_BIT] = q.carry;
      rdata[rsr_pkg::RSR_ST_ZERO_BIT] = q.zero;
      rdata[rsr_pkg::RSR_ST_HALF_BIT] = q.half_carry_flag;
      rdata[rsr_pkg::RSR_ST_BUSY_BIT] = busy;
      rdata[rsr_pkg::RSR_ST_LEVEL_LSB +: LVW] = stack_level;
    end else if (sel == rsr_pkg::RSR_SEL_ACCUM) begin
      rdata[7:0] = q.accumulator_reg;
    end else if (sel == rsr_pkg::RSR_SEL_PC) begin
      rdata[PCW-1:0] = q.pc;
    end else if (sel == rsr_pkg::RSR_SEL_MEM_ADDR) begin
      rdata[6:0] = q.mem_addr;
    end else if (sel == rsr_pkg::RSR_SEL_MEM_DATA) begin
      rdata[7:0] = q.mem[q.mem_addr];
    end else if (sel == rsr_pkg::RSR_SEL_SPEC_ADDR) begin
      rdata[4:0] = q.spec_addr;
    end else if (sel == rsr_pkg::RSR_SEL_SPEC_DATA) begin
      if ({2'h0, q.spec_addr} <= rsr_pkg::RSR_SPEC_LAST) begin
        rdata[7:0] = q.special_function_register[q.spec_addr];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Datapath and sequencing
  // ----------------------------------------------------------------------
  assign alu_operand = (q.op == rsr_pkg::imm_sub_borrow_op) ? q.imm : q.mem[q.raddr];

  rsr_alu u_alu (
    .op(q.op),
    .operand(alu_operand),
    .accum(q.accumulator_reg),
    .carry_in(q.carry),
    .result(alu_result),
    .carry_out(alu_carry),
    .half_out(alu_half),
    .zero_out(alu_zero)
  );

  rsr_stack #(
    .DEPTH(STACK_DEPTH),
    .PCW(PCW),
    .LVW(LVW)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(push),
    .push_data(pwdata[PCW-1:0]),
    .pop(pop),
    .top(stack_top),
    .level(stack_level)
  );

  always_comb begin
    d = q;
    push = 1'h0;
    pop = 1'h0;
    // Read data is captured in the setup cycle, so it stands for the whole access phase.
    if (psel && !penable) begin
      d.prdata = rdata;
    end
    if (wr_fire) begin
      if (sel == rsr_pkg::RSR_SEL_INSTR) begin
        d.op = pwdata[rsr_pkg::RSR_INSTR_OP_LSB +: 3];
        d.dest = pwdata[rsr_pkg::RSR_INSTR_DEST_BIT];
        d.raddr = pwdata[rsr_pkg::RSR_INSTR_ADDR_LSB +: 7];
        d.imm = pwdata[rsr_pkg::RSR_INSTR_IMM_LSB +: 8];
        d.st = rsr_pkg::RSR_EXEC;
      end else if (sel == rsr_pkg::RSR_SEL_STATUS) begin
        d.carry = pwdata[rsr_pkg::RSR_ST_CARRY_BIT];
        d.zero = pwdata[rsr_pkg::RSR_ST_ZERO_BIT];
        d.half_carry_flag = pwdata[rsr_pkg::RSR_ST_HALF_BIT];
      end else if (sel == rsr_pkg::RSR_SEL_ACCUM) begin
        d.accumulator_reg = pwdata[7:0];
      end else if (sel == rsr_pkg::RSR_SEL_PC) begin
        d.pc = pwdata[PCW-1:0];
      end else if (sel == rsr_pkg::RSR_SEL_PUSH) begin
        push = 1'h1;
      end else if (sel == rsr_pkg::RSR_SEL_MEM_ADDR) begin
        d.mem_addr = pwdata[6:0];
      end else if (sel == rsr_pkg::RSR_SEL_MEM_DATA) begin
        d.mem[q.mem_addr] = pwdata[7:0];
      end else if (sel == rsr_pkg::RSR_SEL_SPEC_ADDR) begin
        d.spec_addr = pwdata[4:0];
      end
    end
    case (q.st)
      rsr_pkg::RSR_EXEC: begin
        d.st = rsr_pkg::RSR_IDLE;
        case (q.op)
          rsr_pkg::rotate_left_carry_op, rsr_pkg::rotate_right_carry_op: begin
            d.carry = alu_carry;
            if (q.dest == rsr_pkg::RSR_DEST_ACCUM) begin
              d.accumulator_reg = alu_result;
            end else begin
              d.mem[q.raddr] = alu_result;
            end
          end
          rsr_pkg::reg_sub_borrow_op: begin
            d.carry = alu_carry;
            d.zero = alu_zero;
            d.half_carry_flag = alu_half;
            if (q.dest == rsr_pkg::RSR_DEST_ACCUM) begin
              d.accumulator_reg = alu_result;
            end else begin
              d.mem[q.raddr] = alu_result;
            end
          end
          rsr_pkg::imm_sub_borrow_op: begin
            d.accumulator_reg = alu_result;
            d.carry = alu_carry;
            d.zero = alu_zero;
            d.half_carry_flag = alu_half;
          end
          rsr_pkg::subroutine_return_op: begin
            d.pc = stack_top;
            pop = 1'h1;
            d.st = rsr_pkg::RSR_RETURN_WAIT;
          end
          rsr_pkg::special_page_store_op: begin
            // An index beyond the last entry is dropped silently.
            if (q.raddr <= rsr_pkg::RSR_SPEC_LAST) begin
              d.special_function_register[q.raddr[4:0]] = q.accumulator_reg;
            end
          end
          default: begin
          end
        endcase
      end
      rsr_pkg::RSR_RETURN_WAIT: begin
        d.st = rsr_pkg::RSR_IDLE;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic exec_now;
  logic underflow;
  logic [8:0] sub_sum;

  assign exec_now = (q.st == rsr_pkg::RSR_EXEC);
  assign sub_sum = {1'h0, alu_operand} + {1'h0, ~q.accumulator_reg} + {8'h00, q.carry};
  assign underflow = ({1'h0, alu_operand} < ({1'h0, q.accumulator_reg} + {8'h00, !q.carry}));

  sequence s_return_issue;
    exec_now && (q.op == rsr_pkg::subroutine_return_op);
  endsequence

  sequence s_return_done;
    busy ##1 !busy;
  endsequence

  property p_rotate_left_one_cycle;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.op == rsr_pkg::rotate_left_carry_op) |=>
      !busy && (q.carry == $past(alu_operand[7])) && (q.zero == $past(q.zero));
  endproperty
  a_rotate_left_one_cycle: assert property (p_rotate_left_one_cycle)
    else $error("rotate left carry or timing wrong");

  property p_rotate_left_bits;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.op == rsr_pkg::rotate_left_carry_op) && (q.dest == rsr_pkg::RSR_DEST_ACCUM) |=>
      q.accumulator_reg == {$past(alu_operand[6:0]), $past(q.carry)};
  endproperty
  a_rotate_left_bits: assert property (p_rotate_left_bits)
    else $error("rotate left result wrong");

  property p_rotate_right_bits;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.op == rsr_pkg::rotate_right_carry_op) && (q.dest == rsr_pkg::RSR_DEST_ACCUM) |=>
      (q.accumulator_reg == {$past(q.carry), $past(alu_operand[7:1])}) &&
      (q.carry == $past(alu_operand[0])) && !busy;
  endproperty
  a_rotate_right_bits: assert property (p_rotate_right_bits)
    else $error("rotate right result wrong");

  property p_dest_register_keeps_accum;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.dest == rsr_pkg::RSR_DEST_REG) && (q.op != rsr_pkg::imm_sub_borrow_op) |=>
      q.accumulator_reg == $past(q.accumulator_reg);
  endproperty
  a_dest_register_keeps_accum: assert property (p_dest_register_keeps_accum)
    else $error("register destination changed the accumulator");

  property p_return_two_cycles;
    @(posedge pclk) disable iff (!presetn)
    s_return_issue |=> (q.pc == $past(stack_top)) && (q.carry == $past(q.carry)) ##0 s_return_done;
  endproperty
  a_return_two_cycles: assert property (p_return_two_cycles)
    else $error("return did not load pc in two cycles");

  property p_return_level;
    @(posedge pclk) disable iff (!presetn)
    s_return_issue ##0 (stack_level != '0) |=> stack_level == $past(stack_level) - 1'h1;
  endproperty
  a_return_level: assert property (p_return_level)
    else $error("return did not drop the stack level");

  property p_reg_sub_flags;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.op == rsr_pkg::reg_sub_borrow_op) && (q.dest == rsr_pkg::RSR_DEST_ACCUM) |=>
      (q.accumulator_reg == $past(sub_sum[7:0])) && (q.carry == $past(sub_sum[8]));
  endproperty
  a_reg_sub_flags: assert property (p_reg_sub_flags)
    else $error("register subtract result wrong");

  property p_imm_sub;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.op == rsr_pkg::imm_sub_borrow_op) |=>
      (q.accumulator_reg == $past(sub_sum[7:0])) && !busy;
  endproperty
  a_imm_sub: assert property (p_imm_sub)
    else $error("immediate subtract result wrong");

  property p_special_store;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.op == rsr_pkg::special_page_store_op) && (q.raddr <= rsr_pkg::RSR_SPEC_LAST) |=>
      (q.special_function_register[$past(q.raddr[4:0])] == $past(q.accumulator_reg)) &&
      (q.carry == $past(q.carry)) && (q.zero == $past(q.zero)) && !busy;
  endproperty
  a_special_store: assert property (p_special_store)
    else $error("special page store wrong");

  property p_borrow_and_zero;
    @(posedge pclk) disable iff (!presetn)
    exec_now && (q.op == rsr_pkg::imm_sub_borrow_op) |=>
      (q.carry == !$past(underflow)) && (q.zero == (q.accumulator_reg == 8'h00));
  endproperty
  a_borrow_and_zero: assert property (p_borrow_and_zero)
    else $error("borrow or zero flag wrong");

endmodule
`default_nettype wire

// ===== bench/rsr_exec_bench.sv
// Self-checking bench for the rotate, subtract and return execution block.
// Assumes the block's APB slave and register map; a queue-based model predicts every result.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module rsr_exec_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  integer seed = 32'h7096;
  int failures = 0;
  int checked = 0;
  int stalls, sn, sr, acc, cf, zf, hf, r, a, ad, d, im, fl, si, op, sum, res, p1, p2;
  int mem[128];
  int spec[22];
  int stk[$];
  int ops[5] = '{0, 1, 3, 4, 5};

  rsr_exec #(.PCW(10), .STACK_DEPTH(8), .MEM_DEPTH(128)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  // Transfers run back to back; psel stays high so no signal is driven twice per step.
  task automatic apb(input logic wr, input logic [11:0] ad_i, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= ad_i;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    stalls = 0;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 50) begin
      stalls++;
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      failures++;
      $display("[ERR] pready expected 1 seen stuck");
      end_sim();
    end
    rd = prdata;
    err = pslverr;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    failures++;
    $display("[ERR] watchdog expected finish seen hang");
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    acc = 0;
    cf = 0;
    zf = 0;
    hf = 0;
    foreach (mem[i]) mem[i] = 0;
    foreach (spec[i]) spec[i] = 0;
    apb(1'h0, rsr_pkg::RSR_OFF_STATUS, 32'h0);
    `CHK("status", 0, rd)
    apb(1'h0, rsr_pkg::RSR_OFF_ACCUM, 32'h0);
    `CHK("accum", 0, rd)
    apb(1'h0, 12'h024, 32'h0);
    `CHK("unmapped err", 1, err)
    `CHK("unmapped data", 0, rd)
    $display("test reset and unmapped done");

    // Every eighth pass makes operand equal accumulator with carry set, so subtracts hit zero.
    for (int i = 0; i < 60; i++) begin
      op = ops[$unsigned($random(seed)) % 5];
      a = $random(seed) & 255;
      r = (i % 8 == 0) ? a : ($random(seed) & 255);
      ad = $random(seed) & 127;
      d = $random(seed) & 1;
      im = (i % 8 == 0) ? a : ($random(seed) & 255);
      fl = (i % 8 == 0) ? 1 : ($random(seed) & 7);
      si = $unsigned($random(seed)) % 24;
      apb(1'h1, rsr_pkg::RSR_OFF_ACCUM, 32'(a));
      apb(1'h1, rsr_pkg::RSR_OFF_STATUS, 32'(fl));
      apb(1'h1, rsr_pkg::RSR_OFF_MEM_ADDR, 32'(ad));
      apb(1'h1, rsr_pkg::RSR_OFF_MEM_DATA, 32'(r));
      acc = a;
      cf = fl & 1;
      zf = (fl >> 1) & 1;
      hf = (fl >> 2) & 1;
      mem[ad] = r;
      apb(1'h1, rsr_pkg::RSR_OFF_INSTR,
          32'(op | (d << 3) | ((op == 5 ? si : ad) << 8) | (im << 16)));
      case (op)
        0: begin
          res = ((r << 1) | cf) & 255;
          cf = r >> 7;
        end
        1: begin
          res = (cf << 7) | (r >> 1);
          cf = r & 1;
        end
        5: begin
          if (si <= 21) spec[si] = acc;
        end
        default: begin
          sum = (op == 4 ? im : r) + (~acc & 255) + cf;
          res = sum & 255;
          hf = ((op == 4 ? im : r) & 15) + (~acc & 15) + cf > 15 ? 1 : 0;
          cf = sum >> 8;
          zf = (res == 0) ? 1 : 0;
        end
      endcase
      if (op != 5) begin
        if (op == 4 || d == 0) acc = res;
        else mem[ad] = res;
      end
      apb(1'h1, rsr_pkg::RSR_OFF_MEM_ADDR, 32'(ad));
      apb(1'h0, rsr_pkg::RSR_OFF_MEM_DATA, 32'h0);
      `CHK("register", mem[ad], rd)
      apb(1'h0, rsr_pkg::RSR_OFF_ACCUM, 32'h0);
      `CHK("accumulator", acc, rd)
      apb(1'h0, rsr_pkg::RSR_OFF_STATUS, 32'h0);
      `CHK("flags", (hf << 2) | (zf << 1) | cf, rd & 15)
      apb(1'h0, rsr_pkg::RSR_OFF_INSTR, 32'h0);
      `CHK("instruction", op | (d << 3) | ((op == 5 ? si : ad) << 8) | (im << 16), rd)
      if (op == 5) begin
        apb(1'h1, rsr_pkg::RSR_OFF_SPEC_ADDR, 32'(si));
        apb(1'h0, rsr_pkg::RSR_OFF_SPEC_DATA, 32'h0);
        `CHK("special", (si <= 21) ? spec[si] : 0, rd)
      end
    end
    $display("test random operations done");

    // A reset in mid-run must clear the accumulator left by the loop; the loop never writes the program counter, which must still read zero.
    psel <= 1'h0;
    penable <= 1'h0;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, rsr_pkg::RSR_OFF_PC, 32'h0);
    `CHK("pc after reset", 0, rd)
    apb(1'h0, rsr_pkg::RSR_OFF_ACCUM, 32'h0);
    `CHK("accum after reset", 0, rd)
    $display("test mid-run reset done");

    p1 = $random(seed) & 1023;
    p2 = $random(seed) & 1023;
    apb(1'h1, rsr_pkg::RSR_OFF_PUSH, 32'(p1));
    apb(1'h1, rsr_pkg::RSR_OFF_PUSH, 32'(p2));
    stk.push_back(p1);
    stk.push_back(p2);
    apb(1'h1, rsr_pkg::RSR_OFF_PC, 32'(p2 ^ 1023));
    apb(1'h0, rsr_pkg::RSR_OFF_PC, 32'h0);
    `CHK("pc write", p2 ^ 1023, rd)
    apb(1'h1, rsr_pkg::RSR_OFF_STATUS, 32'h5);
    // A one-cycle op ends while the next write is still in setup, so that write never stalls.
    apb(1'h1, rsr_pkg::RSR_OFF_INSTR, 32'h6);
    apb(1'h1, rsr_pkg::RSR_OFF_MEM_ADDR, 32'h0);
    sn = stalls;
    `CHK("one cycle stall", 0, sn)
    // The last pass returns on an empty stack, which loads zero and keeps the level.
    for (int k = 2; k >= 0; k--) begin
      apb(1'h1, rsr_pkg::RSR_OFF_INSTR, 32'h2);
      apb(1'h1, rsr_pkg::RSR_OFF_MEM_ADDR, 32'h0);
      sr = stalls;
      `CHK("return cycles", 1, sr)
      p1 = (k > 0) ? stk.pop_back() : 0;
      apb(1'h0, rsr_pkg::RSR_OFF_PC, 32'h0);
      `CHK("pc", p1, rd)
      apb(1'h0, rsr_pkg::RSR_OFF_STATUS, 32'h0);
      `CHK("level", (k > 0) ? k - 1 : 0, (rd >> 8) & 15)
      `CHK("flags kept", 5, rd & 15)
    end
    $display("test return done");
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    end_sim();
  end
endmodule
`default_nettype wire
